// ==== verilog/adsq_ctrl.v ====
/*
 * Converter sequencing and reference control: APB registers, start pulse
 * detection, 16-period conversion sequence, analog routing controls.
 * Assumes the analog core presents a 12-bit result on conv_data by the end
 * of the conversion; all signals on pclk, pins synchronised before this block.
 */
`timescale 1ns/100ps
`default_nettype none
`include "adsq_regs.vh"

module adsq_ctrl (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata_ff,
    output reg pready_ff,
    output reg pslverr_ff,
    input wire [11:0] conv_data,
    input wire irq_enable,
    output reg irq_ff,
    output reg conv_power_ff,
    output reg conv_sample_ff,
    output reg conv_active_ff,
    output reg [2:0] amp_gain_ff,
    output reg amp_enable_ff,
    output reg amp_input_bandgap_ff,
    output reg amp_ref_pin_connect_ff,
    output reg bandgap_enable_ff,
    output reg [1:0] ref_route_ff,
    output reg ext_ref_pin_connect_ff,
    output reg [8:0] ext_channel_onehot_ff,
    output reg [3:0] internal_source_ff,
    output reg [7:0] pin_analog_ff,
    output reg [7:0] pin_pullup_disable_ff,
    output reg [7:0] pin_dir_override_ff
);

    // Internal source codes toward the analog mux
    localparam [3:0] SRC_EXT = 4'h0;
    localparam [3:0] SRC_VDD = 4'h1;
    localparam [3:0] SRC_VDD2 = 4'h2;
    localparam [3:0] SRC_VDD4 = 4'h3;
    localparam [3:0] SRC_VR = 4'h5;
    localparam [3:0] SRC_VR2 = 4'h6;
    localparam [3:0] SRC_VR4 = 4'h7;
    localparam [3:0] SRC_GND = 4'h8;
    // Reference route codes
    localparam [1:0] REF_SUPPLY = 2'h0;
    localparam [1:0] REF_PIN = 2'h1;
    localparam [1:0] REF_AMP = 2'h2;
    // Gain codes toward the amplifier
    localparam [2:0] GAIN_1 = 3'h0;
    localparam [2:0] GAIN_1P667 = 3'h1;
    localparam [2:0] GAIN_2P5 = 3'h2;
    localparam [2:0] GAIN_3P333 = 3'h3;
    // Sequencer states
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_SAMPLE = 2'h1;
    localparam [1:0] ST_CONVERT = 2'h2;

    reg start_ff;
    reg pulse_high_ff;
    reg busy_ff;
    reg power_ff;
    reg align_ff;
    reg [3:0] chan_ff;
    reg [3:0] src_ff;
    reg [2:0] div_ff;
    reg amp_en_ff;
    reg amp_is_ff;
    reg [1:0] ref_sel_ff;
    reg [1:0] gain_sel_ff;
    reg bgr_ff;
    reg [7:0] res_lo_ff;
    reg [7:0] res_hi_ff;
    reg [7:0] pin_sel_ff;
    reg flag_ff;
    reg [1:0] state_ff;
    reg [4:0] period_ff;
    reg [7:0] nxt_lo;
    reg [7:0] nxt_hi;
    reg [7:0] rd_byte;
    reg rd_err;
    wire wr_en;
    wire acc;
    wire tick;
    wire launch;
    wire done;
    wire flag_clr;

    // External channel selected when source is 0000, 0100 or 11xx
    function is_external;
        input [3:0] code;
        begin
            is_external = (code == 4'h0) || (code == 4'h4) || (code[3:2] == 2'b11);
        end
    endfunction

    // One wait state: every access completes in its second access cycle
    assign acc = psel && penable;
    assign wr_en = acc && pwrite && !pready_ff;

    // Start bit pulse: a high then a low write launches, unless busy or powered down
    assign launch = start_ff == 1'b0 && pulse_high_ff && !busy_ff && power_ff;
    assign done = (state_ff == ST_CONVERT) && tick && (period_ff == `ADSQ_TOTAL_PERIODS - 5'h01);
    assign flag_clr = wr_en && (paddr == `ADSQ_IRQ_ADDR) && pwdata[0];

    adsq_clk_div u_div (
        .pclk(pclk),
        .presetn(presetn),
        .restart(launch),
        .div_sel(div_ff),
        .tick_ff(tick)
    );

    // Register writes and the start pulse tracker
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_ff <= 1'b0;
            pulse_high_ff <= 1'b0;
            power_ff <= 1'b0;
            align_ff <= 1'b0;
            chan_ff <= 4'h0;
            src_ff <= 4'h0;
            div_ff <= 3'h0;
            amp_en_ff <= 1'b0;
            amp_is_ff <= 1'b0;
            ref_sel_ff <= 2'h0;
            gain_sel_ff <= 2'h0;
            bgr_ff <= 1'b0;
            pin_sel_ff <= `ADSQ_RST_BYTE;
        end else begin
            // The high phase is remembered until the low write completes it
            if (start_ff)
                pulse_high_ff <= 1'b1;
            else
                pulse_high_ff <= 1'b0;
            if (wr_en) begin
                case (paddr)
                    `ADSQ_CTRL_A_ADDR: begin
                        start_ff <= pwdata[`ADSQ_A_START];
                        power_ff <= pwdata[`ADSQ_A_PWR];
                        align_ff <= pwdata[`ADSQ_A_ALIGN];
                        chan_ff <= pwdata[3:0];
                    end
                    `ADSQ_CTRL_B_ADDR: begin
                        src_ff <= pwdata[7:4];
                        div_ff <= pwdata[2:0];
                    end
                    `ADSQ_CTRL_C_ADDR: begin
                        amp_en_ff <= pwdata[`ADSQ_C_AMP_EN];
                        amp_is_ff <= pwdata[`ADSQ_C_AMP_IS];
                        ref_sel_ff <= pwdata[3:2];
                        gain_sel_ff <= pwdata[1:0];
                    end
                    `ADSQ_BGR_ADDR: bgr_ff <= pwdata[0];
                    `ADSQ_PIN_SEL_ADDR: pin_sel_ff <= pwdata[7:0];
                    default: ;
                endcase
            end
        end
    end

    // Sequencer: four sample periods then twelve conversion periods
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_IDLE;
            period_ff <= 5'h00;
            busy_ff <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (launch) begin
                        state_ff <= ST_SAMPLE;
                        period_ff <= 5'h00;
                        busy_ff <= 1'b1;
                    end
                end
                ST_SAMPLE: begin
                    if (tick) begin
                        period_ff <= period_ff + 5'h01;
                        if (period_ff == `ADSQ_SAMPLE_PERIODS - 5'h01)
                            state_ff <= ST_CONVERT;
                    end
                end
                ST_CONVERT: begin
                    if (done) begin
                        state_ff <= ST_IDLE;
                        busy_ff <= 1'b0;
                    end else if (tick) begin
                        period_ff <= period_ff + 5'h01;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                    busy_ff <= 1'b0;
                end
            endcase
            // Power removal aborts a conversion in flight; results kept
            if (!power_ff && state_ff != ST_IDLE) begin
                state_ff <= ST_IDLE;
                busy_ff <= 1'b0;
            end
        end
    end

    // Result formatting by the alignment bit
    always @* begin
        if (align_ff) begin
            nxt_hi = {4'h0, conv_data[11:8]};
            nxt_lo = conv_data[7:0];
        end else begin
            nxt_hi = conv_data[11:4];
            nxt_lo = {conv_data[3:0], 4'h0};
        end
    end

    // Results and completion flag; a set in the clear cycle wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_lo_ff <= `ADSQ_RST_BYTE;
            res_hi_ff <= `ADSQ_RST_BYTE;
            flag_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            if (done) begin
                res_lo_ff <= nxt_lo;
                res_hi_ff <= nxt_hi;
            end
            if (done)
                flag_ff <= 1'b1;
            else if (flag_clr)
                flag_ff <= 1'b0;
            irq_ff <= (flag_ff || done) && irq_enable && !(flag_clr && !done);
        end
    end

    // Read mux; unmapped addresses answer with an error
    always @* begin
        rd_byte = 8'h00;
        rd_err = 1'b0;
        case (paddr)
            `ADSQ_CTRL_A_ADDR: rd_byte = {start_ff, busy_ff, power_ff, align_ff, chan_ff};
            `ADSQ_CTRL_B_ADDR: rd_byte = {src_ff, 1'b0, div_ff};
            `ADSQ_CTRL_C_ADDR: rd_byte = {amp_en_ff, 2'b00, amp_is_ff, ref_sel_ff, gain_sel_ff};
            `ADSQ_BGR_ADDR: rd_byte = {7'h00, bgr_ff};
            `ADSQ_RES_LO_ADDR: rd_byte = res_lo_ff;
            `ADSQ_RES_HI_ADDR: rd_byte = res_hi_ff;
            `ADSQ_PIN_SEL_ADDR: rd_byte = pin_sel_ff;
            `ADSQ_IRQ_ADDR: rd_byte = {7'h00, flag_ff};
            default: rd_err = 1'b1;
        endcase
    end

    // APB answer registered: pready one cycle into the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= acc && !pready_ff;
            pslverr_ff <= acc && !pready_ff && rd_err;
            if (acc && !pready_ff && !pwrite)
                prdata_ff <= {24'h00_0000, rd_byte};
        end
    end

    // Analog routing controls toward the core, muxes and amplifier
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_power_ff <= 1'b0;
            conv_sample_ff <= 1'b0;
            conv_active_ff <= 1'b0;
            amp_gain_ff <= GAIN_1;
            amp_enable_ff <= 1'b0;
            amp_input_bandgap_ff <= 1'b0;
            amp_ref_pin_connect_ff <= 1'b0;
            bandgap_enable_ff <= 1'b0;
            ref_route_ff <= REF_SUPPLY;
            ext_ref_pin_connect_ff <= 1'b0;
            ext_channel_onehot_ff <= 9'h000;
            internal_source_ff <= SRC_EXT;
            pin_analog_ff <= 8'h00;
            pin_pullup_disable_ff <= 8'h00;
            pin_dir_override_ff <= 8'h00;
        end else begin
            conv_power_ff <= power_ff;
            conv_sample_ff <= state_ff == ST_SAMPLE;
            conv_active_ff <= busy_ff;
            case (gain_sel_ff)
                2'h0: amp_gain_ff <= GAIN_1;
                2'h1: amp_gain_ff <= GAIN_1P667;
                2'h2: amp_gain_ff <= GAIN_2P5;
                default: amp_gain_ff <= GAIN_3P333;
            endcase
            amp_enable_ff <= amp_en_ff;
            amp_input_bandgap_ff <= amp_is_ff;
            amp_ref_pin_connect_ff <= amp_en_ff && !amp_is_ff;
            bandgap_enable_ff <= bgr_ff;
            if (ref_sel_ff == 2'h0)
                ref_route_ff <= REF_SUPPLY;
            else if (ref_sel_ff == 2'h1)
                ref_route_ff <= REF_PIN;
            else
                ref_route_ff <= REF_AMP;
            ext_ref_pin_connect_ff <= ref_sel_ff == 2'h1;
            // Bit 8 is the floating, nonexistent channel
            if (is_external(src_ff)) begin
                ext_channel_onehot_ff <= chan_ff[3] ? 9'h100 : (9'h001 << chan_ff[2:0]);
                internal_source_ff <= SRC_EXT;
            end else begin
                ext_channel_onehot_ff <= 9'h000;
                case (src_ff)
                    4'h1: internal_source_ff <= SRC_VDD;
                    4'h2: internal_source_ff <= SRC_VDD2;
                    4'h3: internal_source_ff <= SRC_VDD4;
                    4'h5: internal_source_ff <= SRC_VR;
                    4'h6: internal_source_ff <= SRC_VR2;
                    4'h7: internal_source_ff <= SRC_VR4;
                    default: internal_source_ff <= SRC_GND;
                endcase
            end
            pin_analog_ff <= pin_sel_ff;
            pin_pullup_disable_ff <= pin_sel_ff;
            pin_dir_override_ff <= pin_sel_ff;
        end
    end

endmodule // adsq_ctrl

`default_nettype wire

// ==== shared/adsq_regs.vh ====
/*
 * Register map, field positions, reset values and timing counts of the
 * converter sequencing and reference control block.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef ADSQ_REGS_VH
`define ADSQ_REGS_VH

// Byte addresses on the APB bus
`define ADSQ_CTRL_A_ADDR 12'h000
`define ADSQ_CTRL_B_ADDR 12'h004
`define ADSQ_CTRL_C_ADDR 12'h008
`define ADSQ_BGR_ADDR 12'h00c
`define ADSQ_RES_LO_ADDR 12'h010
`define ADSQ_RES_HI_ADDR 12'h014
`define ADSQ_PIN_SEL_ADDR 12'h018
`define ADSQ_IRQ_ADDR 12'h01c

// Control register a fields
`define ADSQ_A_START 7
`define ADSQ_A_BUSY 6
`define ADSQ_A_PWR 5
`define ADSQ_A_ALIGN 4
// Control register c fields
`define ADSQ_C_AMP_EN 7
`define ADSQ_C_AMP_IS 4

// Reset values
`define ADSQ_RST_BYTE 8'h00

// Conversion timing in conversion clock periods
`define ADSQ_SAMPLE_PERIODS 5'h04
`define ADSQ_TOTAL_PERIODS 5'h10

`endif

// ==== verilog/adsq_clk_div.v ====
/*
 * Conversion clock divider: one-cycle enable pulse every 2**sel pclk cycles.
 * Assumes a single pclk domain; restart clears the phase.
 */
`timescale 1ns/100ps
`default_nettype none

module adsq_clk_div (
    input wire pclk,
    input wire presetn,
    input wire restart,
    input wire [2:0] div_sel,
    output reg tick_ff
);

    reg [6:0] cnt_ff;
    wire [6:0] limit;

    // Terminal count is divisor minus one
    assign limit = (7'h01 << div_sel) - 7'h01;

    // Free counter; the restart cycle already counts as the first pclk of a
    // period, otherwise every conversion would run one pclk too long
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 7'h00;
            tick_ff <= 1'b0;
        end else if (restart) begin
            cnt_ff <= 7'h01;
            tick_ff <= (limit == 7'h00);
        end else if (cnt_ff >= limit) begin
            cnt_ff <= 7'h00;
            tick_ff <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 7'h01;
            tick_ff <= 1'b0;
        end
    end

endmodule // adsq_clk_div

`default_nettype wire

// ==== tb/adsq_ctrl_props.sv ====
/* Port checker for the converter control block.
 * Bound into adsq_ctrl; everything runs on pclk. */
`timescale 1ns/100ps
`default_nettype none
module adsq_ctrl_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready_ff,
    input wire logic pslverr_ff,
    input wire logic irq_enable,
    input wire logic irq_ff,
    input wire logic conv_sample_ff,
    input wire logic conv_active_ff,
    input wire logic amp_input_bandgap_ff,
    input wire logic amp_ref_pin_connect_ff,
    input wire logic [1:0] ref_route_ff,
    input wire logic ext_ref_pin_connect_ff,
    input wire logic [8:0] ext_channel_onehot_ff,
    input wire logic [3:0] internal_source_ff,
    input wire logic [7:0] pin_analog_ff,
    input wire logic [7:0] pin_pullup_disable_ff,
    input wire logic [7:0] pin_dir_override_ff
);
    logic [11:0] act_ff;
    logic [11:0] smp_ff;
    // Busy window length and its sampling share; the divider is not visible here
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_ff <= 12'h000;
            smp_ff <= 12'h000;
        end else begin
            act_ff <= conv_active_ff ? act_ff + 12'h001 : 12'h000;
            smp_ff <= (conv_active_ff | conv_sample_ff) ? smp_ff + {11'h000, conv_sample_ff} : 12'h000;
        end
    end
    default clocking dcb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_once: assert property (psel && penable && !pready_ff |=> pready_ff ##1 !pready_ff)
        else $error("ready not a single pulse after access");
    chk_err_unmap: assert property (psel && penable && !pready_ff && paddr > 12'h01c |=> pslverr_ff)
        else $error("unmapped access without error");
    chk_err_pair: assert property (pslverr_ff |-> pready_ff)
        else $error("error without ready");
    chk_ext_ref: assert property (ext_ref_pin_connect_ff == (ref_route_ff == 2'h1))
        else $error("reference pin not disconnected");
    chk_int_src: assert property (internal_source_ff != 4'h0 |-> ext_channel_onehot_ff == 9'h000)
        else $error("external channel left on");
    chk_ext_chan: assert property (internal_source_ff == 4'h0 && $past(presetn) |-> $onehot(ext_channel_onehot_ff))
        else $error("external channel not one-hot");
    chk_amp_pin: assert property (amp_input_bandgap_ff |-> !amp_ref_pin_connect_ff)
        else $error("amplifier pin on with bandgap input");
    chk_pin_func: assert property (pin_pullup_disable_ff == pin_analog_ff && pin_dir_override_ff == pin_analog_ff)
        else $error("pin function controls differ");
    chk_conv_len: assert property ($fell(conv_active_ff) |-> act_ff == {smp_ff[9:0], 2'b00} && act_ff[3:0] == 4'h0)
        else $error("conversion length wrong");
    chk_irq_set: assert property ($fell(conv_active_ff) && irq_enable |-> ##[0:1] irq_ff)
        else $error("interrupt missing after completion");
    chk_irq_mask: assert property (!$past(irq_enable) |-> !irq_ff)
        else $error("interrupt while disabled");
    cover property ($fell(conv_active_ff));
    cover property (pslverr_ff);
    cover property (irq_ff);
endmodule // adsq_ctrl_props
bind adsq_ctrl adsq_ctrl_props i_props (.pclk, .presetn, .psel, .penable, .paddr, .pready_ff,
    .pslverr_ff, .irq_enable, .irq_ff, .conv_sample_ff, .conv_active_ff, .amp_input_bandgap_ff,
    .amp_ref_pin_connect_ff, .ref_route_ff, .ext_ref_pin_connect_ff, .ext_channel_onehot_ff,
    .internal_source_ff, .pin_analog_ff, .pin_pullup_disable_ff, .pin_dir_override_ff);
`default_nettype wire

// ==== tb/adsq_core_model.sv ====
/* Behavioural analog core: hands the bench's level to the converter.
 * Assumes conv_active_ff marks the busy window. */
`timescale 1ns/100ps
`default_nettype none
module adsq_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic conv_power_ff,
    input wire logic conv_active_ff,
    input wire logic [11:0] level,
    output logic [11:0] conv_data
);
    // Valid only while powered and busy; toggles elsewhere so stale data shows
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_data <= 12'h5a5;
        end else if (conv_power_ff && conv_active_ff) begin
            conv_data <= level;
        end else begin
            conv_data <= ~conv_data;
        end
    end
endmodule // adsq_core_model
`default_nettype wire

// ==== tb/adsq_ctrl_bench.sv ====
/* Self-checking bench of the converter control block.
 * Drives APB, models the analog core, checks reads through a queue. */
`timescale 1ns/100ps
`default_nettype none
module adsq_ctrl_bench;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic irq_enable = 1'b0, mon = 1'b1, ext;
    logic [11:0] paddr = 12'h000, level = 12'h000, conv_data;
    logic [31:0] pwdata = 32'h0, prdata_ff, rd, r, seed = 32'h00012dcb;
    logic pready_ff, pslverr_ff, irq_ff, conv_power_ff, conv_sample_ff, conv_active_ff;
    logic amp_enable_ff, amp_input_bandgap_ff, amp_ref_pin_connect_ff, bandgap_enable_ff;
    logic ext_ref_pin_connect_ff;
    logic [2:0] amp_gain_ff;
    logic [1:0] ref_route_ff;
    logic [8:0] ext_channel_onehot_ff;
    logic [3:0] internal_source_ff, s;
    logic [7:0] pin_analog_ff, pin_pullup_disable_ff, pin_dir_override_ff, v, a;
    logic [32:0] rdq[$], lenq[$], alen = 33'h0;
    int error_cnt = 0, compares = 0, cyc = 0, n;
    adsq_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_ff,
        .pready_ff, .pslverr_ff, .conv_data, .irq_enable, .irq_ff, .conv_power_ff,
        .conv_sample_ff, .conv_active_ff, .amp_gain_ff, .amp_enable_ff, .amp_input_bandgap_ff,
        .amp_ref_pin_connect_ff, .bandgap_enable_ff, .ref_route_ff, .ext_ref_pin_connect_ff,
        .ext_channel_onehot_ff, .internal_source_ff, .pin_analog_ff, .pin_pullup_disable_ff,
        .pin_dir_override_ff);
    adsq_core_model i_core (.pclk, .presetn, .conv_power_ff, .conv_active_ff, .level, .conv_data);
    always #25 pclk = ~pclk;
    function logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    task check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One APB transfer, then an idle edge so psel never toggles twice at once
    task apb(input logic [11:0] ad, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        paddr <= ad;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No local limit: pready_ff ends this wait, and only the bench timeout stops it if pready_ff never rises
        do
            @(posedge pclk);
        while (pready_ff !== 1'b1);
        rd = prdata_ff;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task rdx(input logic [11:0] ad, input logic [31:0] e, input logic err);
        rdq.push_back({err, e});
        apb(ad, 1'b0, 32'h0);
    endtask
    task finish_test();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Answer watcher: reads against notes, busy windows against lengths, hang guard
    always @(posedge pclk) begin
        if (mon && psel && penable && pready_ff === 1'b1 && !pwrite)
            check("read", {pslverr_ff, prdata_ff}, rdq.pop_front());
        if (conv_active_ff === 1'b1) begin
            alen++;
        end else if (alen != 0) begin
            check("conv length", alen, lenq.pop_front());
            alen = 0;
        end
        cyc++;
        if (cyc > 10000) begin
            error_cnt++;
            finish_test();
        end
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 8; i++) rdx(12'(4 * i), 32'h0, 1'b0);
        rdx(12'h020, 32'h0, 1'b1);
        apb(12'h00c, 1'b1, 32'h000000ff);
        rdx(12'h00c, 32'h1, 1'b0);
        check("bandgap", bandgap_enable_ff, 1'b1);
        repeat (40) @(posedge pclk);
        for (int i = 0; i < 16; i++) begin
            r = rnd();
            v = {r[7:4], 4'(i)};
            apb(12'h008, 1'b1, {24'h0, v});
            rdx(12'h008, {24'h0, v & 8'h9f}, 1'b0);
            check("gain", amp_gain_ff, {1'b0, v[1:0]});
            check("route", ref_route_ff, v[3] ? 2'h2 : {1'b0, v[2]});
            check("ext ref", ext_ref_pin_connect_ff, v[3:2] == 2'h1);
            check("amp", {amp_enable_ff, amp_input_bandgap_ff, amp_ref_pin_connect_ff},
                {v[7], v[4], v[7] & ~v[4]});
        end
        for (int i = 0; i < 16; i++) begin
            r = rnd();
            s = 4'(i);
            ext = s == 4'h0 || s == 4'h4 || s[3:2] == 2'h3;
            apb(12'h004, 1'b1, {24'h0, s, r[3], 3'h4});
            apb(12'h000, 1'b1, {28'h0, r[7:4]});
            apb(12'h018, 1'b1, {24'h0, r[15:8]});
            rdx(12'h004, {24'h0, s, 4'h4}, 1'b0);
            check("source", internal_source_ff, ext ? 4'h0 : (s[3] ? 4'h8 : s));
            check("channel", ext_channel_onehot_ff,
                !ext ? 9'h000 : (r[7] ? 9'h100 : 9'h001 << r[6:4]));
            check("pins", {pin_analog_ff, pin_pullup_disable_ff, pin_dir_override_ff},
                {3{r[15:8]}});
        end
        for (int k = 0; k < 2; k++) begin
            r = rnd();
            irq_enable <= (k == 0);
            level <= r[27:16];
            a = {3'h1, r[0], 4'h0};
            apb(12'h004, 1'b1, k ? 32'h5 : 32'h4);
            apb(12'h000, 1'b1, {24'h0, a});
            repeat (20) @(posedge pclk);
            check("power on", conv_power_ff, 1'b1);
            apb(12'h000, 1'b1, {24'h0, a | 8'h80});
            apb(12'h000, 1'b1, {24'h0, a});
            lenq.push_back(k ? 33'd512 : 33'd256);
            rdx(12'h000, {24'h0, a | 8'h40}, 1'b0);
            apb(12'h000, 1'b1, {24'h0, a | 8'h80});
            apb(12'h000, 1'b1, {24'h0, a});
            mon = 1'b0;
            n = 0;
            do begin
                apb(12'h000, 1'b0, 32'h0);
                n++;
            end while (rd[6] !== 1'b0 && n < 200);
            check("busy poll", rd[6], 1'b0);
            mon = 1'b1;
            rdx(12'h010, {24'h0, a[4] ? level[7:0] : {level[3:0], 4'h0}}, 1'b0);
            rdx(12'h014, {24'h0, a[4] ? {4'h0, level[11:8]} : level[11:4]}, 1'b0);
            rdx(12'h000, {24'h0, a}, 1'b0);
            rdx(12'h01c, 32'h1, 1'b0);
            check("irq", irq_ff, k == 0);
            apb(12'h01c, 1'b1, 32'h1);
            rdx(12'h01c, 32'h0, 1'b0);
        end
        apb(12'h000, 1'b1, 32'h80);
        apb(12'h000, 1'b1, 32'h00);
        repeat (40) @(posedge pclk);
        check("power", {conv_power_ff, conv_active_ff}, 2'h0);
        finish_test();
    end
endmodule // adsq_ctrl_bench
`default_nettype wire
